// *** hw/mibho_alu.sv ***
`timescale 1ns/1ps
module mibho_alu (
    input wire mibho_pkg::mibho_op_t op,
    input wire logic [7:0] operand,
    input wire logic [7:0] acc,
    input wire logic carry_in,
    input wire logic aux_in,
    output logic [7:0] result,
    output logic write_mem,
    output logic write_acc,
    output logic update_zero,
    output logic update_carry,
    output logic carry_out
);
    import mibho_pkg::*;

    function automatic logic over_nine(input logic [3:0] nibble);
        return nibble > BCD_DIGIT_MAX;
    endfunction

    logic fix_low;
    logic fix_high;
    logic [8:0] adjusted;

    always_comb begin
        fix_low = over_nine(acc[3:0]) || aux_in;
        fix_high = over_nine(acc[7:4]) || carry_in;
        unique case ({fix_high, fix_low})
            2'b00: adjusted = {1'b0, acc} + {1'b0, CORR_NONE};
            2'b01: adjusted = {1'b0, acc} + {1'b0, CORR_LOW};
            2'b10: adjusted = {1'b0, acc} + {1'b0, CORR_HIGH};
            2'b11: adjusted = {1'b0, acc} + {1'b0, CORR_BOTH};
        endcase
    end

    always_comb begin
        result = operand;
        write_mem = 1'b0;
        write_acc = 1'b0;
        update_zero = 1'b0;
        update_carry = 1'b0;
        carry_out = carry_in;
        unique case (op)
            OP_INVERT_TO_ACCUMULATOR: begin
                result = ~operand;
                write_acc = 1'b1;
                update_zero = 1'b1;
            end
            OP_DECIMAL_ADJUST_TO_MEMORY: begin
                result = adjusted[7:0];
                write_mem = 1'b1;
                update_carry = 1'b1;
                carry_out = fix_high || adjusted[8];
            end
            OP_SUBTRACT_ONE_IN_PLACE: begin
                result = operand - ONE;
                write_mem = 1'b1;
                update_zero = 1'b1;
            end
            OP_SUBTRACT_ONE_TO_ACCUMULATOR: begin
                result = operand - ONE;
                write_acc = 1'b1;
                update_zero = 1'b1;
            end
            OP_ADD_ONE_IN_PLACE: begin
                result = operand + ONE;
                write_mem = 1'b1;
                update_zero = 1'b1;
            end
            OP_ADD_ONE_TO_ACCUMULATOR: begin
                result = operand + ONE;
                write_acc = 1'b1;
                update_zero = 1'b1;
            end
            OP_POWER_DOWN: begin
                result = operand;
            end
            OP_RESERVED: begin
                result = operand;
            end
        endcase
    end
endmodule

// *** hw/mibho_pkg.sv ***
package mibho_pkg;

    localparam int ADDR_W = 6;
    localparam int DEPTH = 64;

    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_ACC = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_MEM_ADDR = 8'h0C;
    localparam logic [7:0] REG_MEM_DATA = 8'h10;
    localparam logic [7:0] REG_WDOG = 8'h14;

    localparam int CMD_OP_LSB = 0;
    localparam int CMD_ADDR_LSB = 8;
    localparam int WDOG_PRESC_LSB = 8;

    localparam int ST_ZERO = 0;
    localparam int ST_CARRY = 1;
    localparam int ST_AUX = 2;
    localparam int ST_POWER_DOWN = 3;
    localparam int ST_TIMEOUT = 4;
    localparam int ST_BUSY = 5;
    localparam int ST_HALTED = 6;

    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
    localparam logic [7:0] CORR_NONE = 8'h00;
    localparam logic [7:0] CORR_LOW = 8'h06;
    localparam logic [7:0] CORR_HIGH = 8'h60;
    localparam logic [7:0] CORR_BOTH = 8'h66;
    localparam logic [7:0] ONE = 8'h01;

    localparam logic [7:0] WDOG_PRESC_MAX = 8'hFF;
    localparam logic [7:0] WDOG_COUNT_MAX = 8'hFF;

    localparam logic [1:0] APB_WAIT_FETCH = 2'h0;
    localparam logic [1:0] APB_WAIT_ANSWER = 2'h1;

    typedef enum logic [2:0] {
        OP_INVERT_TO_ACCUMULATOR,
        OP_DECIMAL_ADJUST_TO_MEMORY,
        OP_SUBTRACT_ONE_IN_PLACE,
        OP_SUBTRACT_ONE_TO_ACCUMULATOR,
        OP_ADD_ONE_IN_PLACE,
        OP_ADD_ONE_TO_ACCUMULATOR,
        OP_POWER_DOWN,
        OP_RESERVED
    } mibho_op_t;

    typedef enum logic [1:0] {
        EX_IDLE,
        EX_FETCH,
        EX_EXEC
    } mibho_ex_t;

endpackage

// *** hw/mibho_ram.sv ***
`timescale 1ns/1ps
module mibho_ram (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [mibho_pkg::ADDR_W-1:0] addr,
    input wire logic rd_en,
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    output logic [7:0] rd_data
);
    import mibho_pkg::*;

    logic [7:0] mem [DEPTH];

    // Contents are not reset, so they survive power down and wake up.
    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem[addr] <= wr_data;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= 8'h00;
        end else if (rd_en) begin
            rd_data <= mem[addr];
        end
    end
endmodule

// *** hw/mibho_top.sv ***
// Overview of operation
// - Invert to accumulator loads the inverted memory byte, leaves memory alone and touches only zero.
// - Decimal adjust adds six to the low nibble when it is above nine or aux carry is set, else keeps it.
// - Decimal adjust adds six to the high nibble when it is above nine or carry is set.
// - Decimal adjust writes accumulator plus 00H, 06H, 60H or 66H to the addressed memory byte.
// - Decimal adjust changes only carry, which is set when the high nibble is corrected or the sum carries out of bit 7.
// - Subtract one in place writes the memory byte minus one back and touches only zero.
// - Subtract one to accumulator loads the memory byte minus one, leaves memory alone, touches only zero.
// - Add one in place writes the memory byte plus one back and touches only zero.
// - Add one to accumulator loads the memory byte plus one and leaves memory alone.
// - Power down stops executing commands and gates off the system clock.
// - Entering power down keeps memory, the accumulator and the address and command registers as they were.
// - Power down clears the watchdog counter and its prescaler.
// - Power down sets the power down flag, clears the timeout flag and changes no other flag.
`timescale 1ns/1ps
module mibho_top (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic wake,
    output logic sys_clk_en,
    output logic busy
);
    import mibho_pkg::*;

    mibho_ex_t state;
    mibho_op_t op;
    logic [ADDR_W-1:0] op_addr;
    logic [ADDR_W-1:0] mem_addr_reg;
    logic [7:0] acc;
    logic zero;
    logic carry;
    logic aux_carry_flag;
    logic power_down_flag;
    logic watchdog_timeout_flag;
    logic halted;
    logic [7:0] watchdog_counter;
    logic [7:0] watchdog_prescaler;
    logic [1:0] apb_wait;

    logic access;
    logic done;
    logic refuse;
    logic sw_write;
    logic exec;
    logic halt_exec;
    logic wdog_tick;
    logic wdog_overflow;
    logic [ADDR_W-1:0] mem_addr;
    logic mem_rd_en;
    logic mem_wr_en;
    logic [7:0] mem_wr_data;
    logic [7:0] mem_rd_data;
    logic [7:0] alu_result;
    logic alu_write_mem;
    logic alu_write_acc;
    logic alu_update_zero;
    logic alu_update_carry;
    logic alu_carry_out;

    function automatic logic is_mapped(input logic [7:0] a);
        return a == REG_CMD || a == REG_ACC || a == REG_STATUS || a == REG_MEM_ADDR || a == REG_MEM_DATA ||
               a == REG_WDOG;
    endfunction

    function automatic logic is_hit(input logic [7:0] a, input logic [7:0] reg_addr);
        return is_mapped(a) && a == reg_addr;
    endfunction

    // Bus decode and refusal: busy blocks writes and memory reads, a halted core refuses commands.
    always_comb begin
        access = psel && penable;
        done = access && pready;
        refuse = !is_mapped(paddr) || (busy && (pwrite || paddr == REG_MEM_DATA)) ||
                 (halted && pwrite && paddr == REG_CMD);
        sw_write = done && pwrite && !pslverr;
        exec = state == EX_EXEC;
        halt_exec = exec && op == OP_POWER_DOWN;
        wdog_tick = !halted && watchdog_prescaler == WDOG_PRESC_MAX;
        wdog_overflow = wdog_tick && watchdog_counter == WDOG_COUNT_MAX;
    end

    // The execution unit owns the memory port while a command runs.
    always_comb begin
        mem_addr = busy ? op_addr : mem_addr_reg;
        mem_rd_en = (state == EX_FETCH) ||
                    (access && !pready && apb_wait == APB_WAIT_FETCH && !busy && paddr == REG_MEM_DATA);
        mem_wr_en = (exec && alu_write_mem) || (sw_write && is_hit(paddr, REG_MEM_DATA));
        mem_wr_data = exec ? alu_result : pwdata[7:0];
    end

    mibho_ram u_ram (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .addr(mem_addr),
        .rd_en(mem_rd_en),
        .wr_en(mem_wr_en),
        .wr_data(mem_wr_data),
        .rd_data(mem_rd_data)
    );

    mibho_alu u_alu (
        .op(op),
        .operand(mem_rd_data),
        .acc(acc),
        .carry_in(carry),
        .aux_in(aux_carry_flag),
        .result(alu_result),
        .write_mem(alu_write_mem),
        .write_acc(alu_write_acc),
        .update_zero(alu_update_zero),
        .update_carry(alu_update_carry),
        .carry_out(alu_carry_out)
    );

    // Two wait states: one to read memory, one to register the answer.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            apb_wait <= APB_WAIT_FETCH;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (done) begin
            apb_wait <= APB_WAIT_FETCH;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (access && apb_wait == APB_WAIT_FETCH) begin
            apb_wait <= APB_WAIT_ANSWER;
        end else if (access && apb_wait == APB_WAIT_ANSWER) begin
            pready <= 1'b1;
            pslverr <= refuse;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (access && !pready && apb_wait == APB_WAIT_ANSWER) begin
            prdata <= 32'h0000_0000;
            if (!refuse && !pwrite) begin
                unique case (paddr)
                    REG_CMD: begin
                        prdata[CMD_OP_LSB +: 3] <= op;
                        prdata[CMD_ADDR_LSB +: ADDR_W] <= op_addr;
                    end
                    REG_ACC: prdata[7:0] <= acc;
                    REG_STATUS: begin
                        prdata[ST_ZERO] <= zero;
                        prdata[ST_CARRY] <= carry;
                        prdata[ST_AUX] <= aux_carry_flag;
                        prdata[ST_POWER_DOWN] <= power_down_flag;
                        prdata[ST_TIMEOUT] <= watchdog_timeout_flag;
                        prdata[ST_BUSY] <= busy;
                        prdata[ST_HALTED] <= halted;
                    end
                    REG_MEM_ADDR: prdata[ADDR_W-1:0] <= mem_addr_reg;
                    REG_MEM_DATA: prdata[7:0] <= mem_rd_data;
                    REG_WDOG: begin
                        prdata[7:0] <= watchdog_counter;
                        prdata[WDOG_PRESC_LSB +: 8] <= watchdog_prescaler;
                    end
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_addr_reg <= '0;
        end else if (sw_write && is_hit(paddr, REG_MEM_ADDR)) begin
            mem_addr_reg <= pwdata[ADDR_W-1:0];
        end
    end

    // Command sequencer: fetch the operand, then execute in one cycle.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= EX_IDLE;
            op <= OP_RESERVED;
            op_addr <= '0;
            busy <= 1'b0;
        end else begin
            unique case (state)
                EX_IDLE: begin
                    if (sw_write && is_hit(paddr, REG_CMD)) begin
                        op <= mibho_op_t'(pwdata[CMD_OP_LSB +: 3]);
                        op_addr <= pwdata[CMD_ADDR_LSB +: ADDR_W];
                        state <= EX_FETCH;
                        busy <= 1'b1;
                    end
                end
                EX_FETCH: state <= EX_EXEC;
                EX_EXEC: begin
                    state <= EX_IDLE;
                    busy <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc <= ACC_RESET;
        end else if (exec && alu_write_acc) begin
            acc <= alu_result;
        end else if (sw_write && is_hit(paddr, REG_ACC)) begin
            acc <= pwdata[7:0];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            zero <= 1'b0;
            carry <= 1'b0;
            aux_carry_flag <= 1'b0;
        end else if (exec) begin
            if (alu_update_zero) begin
                zero <= alu_result == 8'h00;
            end
            if (alu_update_carry) begin
                carry <= alu_carry_out;
            end
        end else if (sw_write && is_hit(paddr, REG_STATUS)) begin
            zero <= pwdata[ST_ZERO];
            carry <= pwdata[ST_CARRY];
            aux_carry_flag <= pwdata[ST_AUX];
        end
    end

    // A watchdog timeout wins over a software clear in the same cycle.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            power_down_flag <= 1'b0;
            watchdog_timeout_flag <= 1'b0;
        end else if (halt_exec) begin
            power_down_flag <= 1'b1;
            watchdog_timeout_flag <= 1'b0;
        end else begin
            if (wdog_overflow) begin
                watchdog_timeout_flag <= 1'b1;
            end else if (sw_write && is_hit(paddr, REG_STATUS)) begin
                watchdog_timeout_flag <= pwdata[ST_TIMEOUT];
            end
            if (sw_write && is_hit(paddr, REG_STATUS)) begin
                power_down_flag <= pwdata[ST_POWER_DOWN];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            halted <= 1'b0;
            sys_clk_en <= 1'b1;
        end else if (halt_exec) begin
            halted <= 1'b1;
            sys_clk_en <= 1'b0;
        end else if (wake) begin
            halted <= 1'b0;
            sys_clk_en <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            watchdog_counter <= 8'h00;
            watchdog_prescaler <= 8'h00;
        end else if (halt_exec) begin
            watchdog_counter <= 8'h00;
            watchdog_prescaler <= 8'h00;
        end else if (!halted) begin
            watchdog_prescaler <= watchdog_prescaler + ONE;
            if (wdog_tick) begin
                watchdog_counter <= watchdog_counter + ONE;
            end
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    invert_acc_a: assert property (exec && op == OP_INVERT_TO_ACCUMULATOR |->
        !mem_wr_en ##1 acc == ~$past(mem_rd_data))
        else $error("invert to accumulator result wrong");
    toacc_flags_a: assert property (exec && (op == OP_INVERT_TO_ACCUMULATOR ||
        op == OP_SUBTRACT_ONE_TO_ACCUMULATOR) |=> $stable(carry) && $stable(aux_carry_flag))
        else $error("accumulator command changed a flag other than zero");
    adjust_low_a: assert property (exec && op == OP_DECIMAL_ADJUST_TO_MEMORY |->
        ((mem_wr_data - acc) & 8'h0F) == ((acc[3:0] > 4'h9 || aux_carry_flag) ? 8'h06 : 8'h00))
        else $error("decimal adjust low nibble wrong");
    adjust_high_a: assert property (exec && op == OP_DECIMAL_ADJUST_TO_MEMORY |->
        ((mem_wr_data - acc) & 8'hF0) == ((acc[7:4] > 4'h9 || carry) ? 8'h60 : 8'h00))
        else $error("decimal adjust high nibble wrong");
    adjust_write_a: assert property (exec && op == OP_DECIMAL_ADJUST_TO_MEMORY |->
        mem_wr_en && mem_addr == op_addr)
        else $error("decimal adjust not written to memory");
    adjust_acc_a: assert property (exec && op == OP_DECIMAL_ADJUST_TO_MEMORY |=> $stable(acc))
        else $error("decimal adjust changed the accumulator");
    adjust_flags_a: assert property (exec && op == OP_DECIMAL_ADJUST_TO_MEMORY |=>
        $stable(zero) && $stable(aux_carry_flag) && carry == ($past(acc[7:4]) > 4'h9 || $past(carry) ||
        $past(mem_wr_data) < $past(acc)))
        else $error("decimal adjust flags wrong");
    sub_place_a: assert property (exec && op == OP_SUBTRACT_ONE_IN_PLACE |->
        mem_wr_en && mem_wr_data == mem_rd_data - 8'h01 ##1 $stable(acc))
        else $error("subtract one in place wrong");
    sub_acc_a: assert property (exec && op == OP_SUBTRACT_ONE_TO_ACCUMULATOR |->
        !mem_wr_en ##1 acc == $past(mem_rd_data) - 8'h01)
        else $error("subtract one to accumulator wrong");
    inc_place_a: assert property (exec && op == OP_ADD_ONE_IN_PLACE |->
        mem_wr_en && mem_wr_data == mem_rd_data + 8'h01 ##1 $stable(acc))
        else $error("add one in place wrong");
    inc_acc_a: assert property (exec && op == OP_ADD_ONE_TO_ACCUMULATOR |->
        !mem_wr_en ##1 acc == $past(mem_rd_data) + 8'h01)
        else $error("add one to accumulator wrong");
    inplace_flags_a: assert property (exec && (op == OP_SUBTRACT_ONE_IN_PLACE ||
        op == OP_ADD_ONE_IN_PLACE) |=> $stable(carry) && $stable(aux_carry_flag))
        else $error("in place command changed a flag other than zero");
    halt_stop_a: assert property (halt_exec |=> !sys_clk_en && halted && state == EX_IDLE)
        else $error("power down did not stop the core");
    halt_hold_a: assert property (halted |=> state == EX_IDLE && !busy)
        else $error("halted core started a command");
    cmd_refuse_a: assert property (pready && !pslverr && pwrite && paddr == REG_CMD |-> !halted)
        else $error("command accepted while halted");
    wdog_frozen_a: assert property (halted |=> $stable(watchdog_counter) && $stable(watchdog_prescaler))
        else $error("watchdog ran while halted");
    wake_resume_a: assert property (halted && wake |=> !halted && sys_clk_en)
        else $error("wake did not restart the clock");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("bus ready held longer than one cycle");
    halt_keep_a: assert property (halt_exec |-> !mem_wr_en ##1 $stable(acc) && $stable(mem_addr_reg))
        else $error("power down changed state");
    halt_regs_a: assert property (halt_exec |=> $stable(op) && $stable(op_addr))
        else $error("power down changed the command registers");
    halt_wdog_a: assert property (halt_exec |=> watchdog_counter == 8'h00 && watchdog_prescaler == 8'h00)
        else $error("power down did not clear watchdog");
    halt_flags_a: assert property (halt_exec |=> power_down_flag && !watchdog_timeout_flag &&
        $stable(zero) && $stable(carry) && $stable(aux_carry_flag))
        else $error("power down flags wrong");
    zero_flag_a: assert property (exec && alu_update_zero |=> zero == ($past(alu_result) == 8'h00))
        else $error("zero flag wrong");
endmodule

// *** test/tb_top.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; \
    $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_top;
    import mibho_pkg::*;
    logic ref_clk, rst_n, psel, penable, pwrite, wake, pready, pslverr, sys_clk_en, busy, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, d;
    logic [20:0] e;
    logic [7:0] da_a [6] = '{8'h9A, 8'h00, 8'hA0, 8'h00, 8'h99, 8'hFF};
    logic [4:0] da_f [6] = '{5'h00, 5'h04, 5'h00, 5'h02, 5'h00, 5'h00};
    logic [7:0] ed_m [6] = '{8'hFF, 8'h01, 8'h00, 8'h01, 8'hFF, 8'h00};
    logic [2:0] ed_o [6] = '{3'h4, 3'h2, 3'h3, 3'h3, 3'h5, 3'h0};
    integer seed = 32'h8A90FA75;
    int err_count = 0;
    int comparisons = 0;
    mibho_top dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .wake(wake), .sys_clk_en(sys_clk_en), .busy(busy));
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic close_out();
        $display("comparisons=%0d err_count=%0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd, output logic [31:0] rd,
        output logic ef);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge ref_clk);
        end
        if (n >= 20) err_count++;
        rd = prdata;
        ef = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
        logic [31:0] x;
        logic y;
        apb(1'b1, ad, wd, x, y);
    endtask
    task automatic rd(input logic [7:0] ad, output logic [31:0] v);
        logic y;
        apb(1'b0, ad, 32'h0, v, y);
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        @(posedge ref_clk);
        @(posedge ref_clk);
        while (busy !== 1'b0 && n < 20) begin
            n++;
            @(posedge ref_clk);
        end
        if (n >= 20) err_count++;
    endtask
    // Returns expected memory byte, accumulator and flags after one command.
    function automatic logic [20:0] model(input logic [2:0] op, input logic [7:0] m, a, input logic [4:0] f);
        logic [7:0] nm, na, c;
        logic [4:0] nf;
        logic [8:0] s;
        logic lo, hi;
        nm = m;
        na = a;
        nf = f;
        lo = a[3:0] > 4'h9 || f[ST_AUX];
        hi = a[7:4] > 4'h9 || f[ST_CARRY];
        case (op)
            3'h0: na = ~m;
            3'h1: begin
                c = {hi ? 4'h6 : 4'h0, lo ? 4'h6 : 4'h0};
                s = {1'b0, a} + {1'b0, c};
                nm = s[7:0];
                nf[ST_CARRY] = hi | s[8];
            end
            3'h2: nm = m - 8'h01;
            3'h3: na = m - 8'h01;
            3'h4: nm = m + 8'h01;
            3'h5: na = m + 8'h01;
            default: ;
        endcase
        if (op != 3'h1 && op < 3'h6) nf[ST_ZERO] = (((op == 3'h2) || (op == 3'h4)) ? nm : na) == 8'h00;
        return {nm, na, nf};
    endfunction
    task automatic run_op(input logic [2:0] op, input logic [5:0] ad, input logic [7:0] m, a,
        input logic [4:0] f);
        wr(REG_MEM_ADDR, {26'h0, ad});
        wr(REG_MEM_DATA, {24'h0, m});
        wr(REG_ACC, {24'h0, a});
        wr(REG_STATUS, {27'h0, f});
        wr(REG_CMD, {18'h0, ad, 5'h0, op});
        wait_idle();
        e = model(op, m, a, f);
        rd(REG_ACC, d);
        `CHK(d[7:0], e[12:5])
        rd(REG_MEM_DATA, d);
        `CHK(d[7:0], e[20:13])
        rd(REG_STATUS, d);
        `CHK(d[6:0], {2'b00, e[4:0]})
    endtask
    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        wake = 1'b0;
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(REG_ACC, d);
        `CHK(d, 32'h0)
        rd(REG_STATUS, d);
        `CHK(d[6:0], 7'h00)
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            run_op(3'h1, 6'(i + 3), 8'h00, da_a[i], da_f[i]);
            run_op(ed_o[i], 6'(i + 9), ed_m[i], 8'h5A, 5'h1B);
        end
        run_op(3'h7, 6'h2A, 8'h81, 8'h00, 5'h07);
        $display("test corners done");
        for (int i = 0; i < 30; i++) begin
            run_op(3'($unsigned($random(seed)) % 6), 6'($random(seed)), 8'($random(seed)), 8'($random(seed)),
                5'($random(seed)));
        end
        $display("test random done");
        apb(1'b1, 8'h18, 32'h1, d, er);
        `CHK(er, 1'b1)
        apb(1'b0, 8'h1C, 32'h0, d, er);
        `CHK({er, d}, {1'b1, 32'h0})
        $display("test unmapped done");
        run_op(3'h0, 6'h20, 8'h3C, 8'h77, 5'h10);
        wr(REG_STATUS, 32'h16);
        repeat (300) @(posedge ref_clk);
        wr(REG_CMD, {18'h0, 6'h20, 5'h0, 3'h6});
        wait_idle();
        repeat (2) @(posedge ref_clk);
        #1;
        `CHK(sys_clk_en, 1'b0)
        rd(REG_STATUS, d);
        `CHK(d[6:0], 7'h4E)
        rd(REG_WDOG, d);
        `CHK(d[15:0], 16'h0)
        apb(1'b1, REG_CMD, {18'h0, 6'h20, 5'h0, 3'h5}, d, er);
        `CHK(er, 1'b1)
        rd(REG_ACC, d);
        `CHK(d[7:0], 8'hC3)
        rd(REG_MEM_DATA, d);
        `CHK(d[7:0], 8'h3C)
        @(posedge ref_clk);
        wake <= 1'b1;
        @(posedge ref_clk);
        wake <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        `CHK(sys_clk_en, 1'b1)
        rd(REG_STATUS, d);
        `CHK(d[6:0], 7'h0E)
        $display("test power down done");
        close_out();
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        close_out();
    end
endmodule
